// *** rtl/prog_link_pkg.sv ***
// Constants and types shared by the programming link physical layer
`default_nettype none
package prog_link_pkg;
   localparam int unsigned DATA_BITS      = 8;
   localparam int unsigned STOP_BITS      = 2;
   localparam int unsigned BREAK_BITS     = 12;
   localparam int unsigned ENABLE_IDLE    = 16;
   localparam int unsigned IDLE_MIN_BITS  = 2;
   localparam logic [7:0]  GUARD_RESET    = 8'h80;
   localparam logic [3:0]  BIT_CNT_LAST   = 4'h0;
   localparam logic [3:0]  RX_FRAME_BITS  = 4'hB;
   localparam logic [3:0]  TX_FRAME_BITS  = 4'hC;
   typedef enum logic [2:0] {
      ST_OFF,
      ST_RX_IDLE,
      ST_RX_SHIFT,
      ST_TX_GUARD,
      ST_TX_SHIFT,
      ST_TX_DONE
   } phy_state_t;
endpackage
`default_nettype wire

// *** rtl/link_sync.sv ***
// Two flip-flop synchroniser for a group of pin levels
`default_nettype none
module link_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// *** rtl/prog_link_phy_layer.sv ***
// Half-duplex three pin programming link physical layer
`default_nettype none
module prog_link_phy_layer
   import prog_link_pkg::*;
(
   // System
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Pins
   input  wire logic       prog_link_clock_pin,
   input  wire logic       prog_link_data_pin_in,
   output logic            prog_link_data_pin_out,
   output logic            prog_link_data_pin_oe,
   input  wire logic       reset_pin_low,
   input  wire logic       reset_pin_high_voltage,
   // Configuration
   input  wire logic       reset_pin_disable_fuse,
   input  wire logic       memory_access_enable_bit,
   input  wire logic [7:0] phy_guard_time_control,
   input  wire logic       guard_time_load,
   // Access layer
   input  wire logic       tx_mode_select,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   output logic            tx_done,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   output logic            frame_error,
   output logic            parity_error,
   output logic            break_detected,
   output logic            collision,
   output logic            link_enabled
);
   typedef struct packed {
      phy_state_t  state;
      logic        clk_prev;
      logic [10:0] shift;
      logic [3:0]  bit_cnt;
      logic        par_acc;
      logic        all_zero;
      logic [8:0]  guard_cnt;
      logic [7:0]  guard_cfg;
      logic        drv_one;
      logic        out_bit;
      logic        out_oe;
      logic        rx_valid;
      logic        frame_err;
      logic        par_err;
      logic        brk;
      logic        coll;
      logic        tx_ready;
      logic        tx_done;
      logic [7:0]  rx_data;
      logic        enabled;
      logic        was_enabled;
   } phy_reg_t;

   phy_reg_t r_q;
   phy_reg_t r_d;

   logic [4:0] pins_sync;
   logic       lclk;
   logic       ldata;
   logic       rst_low_s;
   logic       hv_s;
   logic       fuse_s;
   logic       rise;
   logic       fall;
   logic       session_req;

   // Pin levels cross into the system clock domain
   link_sync #(
      .WIDTH (5)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in ({prog_link_clock_pin, prog_link_data_pin_in, reset_pin_low,
                  reset_pin_high_voltage, reset_pin_disable_fuse}),
      .sync_out (pins_sync)
   );

   assign lclk      = pins_sync[4];
   assign ldata     = pins_sync[3];
   assign rst_low_s = pins_sync[2];
   assign hv_s      = pins_sync[1];
   assign fuse_s    = pins_sync[0];

   // Edges of the sampled link clock
   assign rise = lclk & ~r_q.clk_prev;
   assign fall = ~lclk & r_q.clk_prev;

   // Enable source depends on reset pin disable fuse
   assign session_req = fuse_s ? hv_s : rst_low_s;

   // Next state
   always_comb
   begin
      r_d           = r_q;
      r_d.clk_prev  = lclk;
      r_d.rx_valid  = 1'b0;
      r_d.frame_err = 1'b0;
      r_d.par_err   = 1'b0;
      r_d.brk       = 1'b0;
      r_d.coll      = 1'b0;
      r_d.tx_done   = 1'b0;
      if (guard_time_load)
      begin
         r_d.guard_cfg = phy_guard_time_control;
      end

      // Session on while pin asserted, kept if memory access is on
      if (session_req)
      begin
         r_d.enabled = 1'b1;
      end
      else if (!memory_access_enable_bit)
      begin
         r_d.enabled = 1'b0;
      end  // Else session survives release
      r_d.was_enabled = r_d.enabled;

      if (!r_q.enabled)
      begin
         r_d.state    = ST_OFF;
         r_d.out_oe   = 1'b0;
         r_d.tx_ready = 1'b0;
      end
      else
      begin
         case (r_q.state)
            ST_OFF:
            begin
               // Physical layer initialised: receive mode, default guard
               r_d.state     = ST_RX_IDLE;
               r_d.guard_cfg = GUARD_RESET;
               r_d.out_oe    = 1'b0;
               r_d.all_zero  = 1'b0;
            end
            ST_RX_IDLE:
            begin
               r_d.out_oe = 1'b0;
               if (tx_mode_select)
               begin
                  // Direction only on access layer request
                  r_d.state     = ST_TX_GUARD;
                  r_d.guard_cnt = {1'b0, r_q.guard_cfg} + 9'(IDLE_MIN_BITS);
               end
               else if (rise && ldata)
               begin
                  // Line seen high, so any break tail is over
                  r_d.all_zero = 1'b0;
               end
               else if (rise && !r_q.all_zero)
               begin
                  // First low sample is the start bit; lows trailing a break are skipped
                  r_d.state    = ST_RX_SHIFT;
                  r_d.bit_cnt  = RX_FRAME_BITS;
                  r_d.par_acc  = 1'b0;
                  r_d.all_zero = 1'b1;
               end
            end
            ST_RX_SHIFT:
            begin
               if (rise)
               begin
                  // Bits enter at the top, so D0 ends at bit 0
                  r_d.shift    = {ldata, r_q.shift[10:1]};
                  r_d.bit_cnt  = r_q.bit_cnt - 4'h1;
                  r_d.all_zero = r_q.all_zero & ~ldata;
                  if (r_q.bit_cnt > 4'h3)
                  begin
                     r_d.par_acc = r_q.par_acc ^ ldata;
                  end
                  if (r_q.bit_cnt == 4'h1)
                  begin
                     r_d.state   = ST_RX_IDLE;
                     r_d.rx_data = r_d.shift[7:0];
                     r_d.rx_valid = 1'b1;
                     if (r_d.all_zero)
                     begin
                        // Break wins; longer low just restarts idle search
                        r_d.brk = 1'b1;
                     end
                     else
                     begin
                        r_d.frame_err = ~r_d.shift[9] | ~r_d.shift[10];
                        r_d.par_err   = r_q.par_acc ^ r_d.shift[8];
                     end
                  end
               end
            end
            ST_TX_GUARD:
            begin
               r_d.out_oe = 1'b0;
               if (!tx_mode_select)
               begin
                  // Offer withdrawn with the mode, so no stale ready in receive
                  r_d.state    = ST_RX_IDLE;
                  r_d.tx_ready = 1'b0;
               end
               else if (fall)
               begin
                  // Idle bits held by pull-up; ready on the last of guard plus two
                  if (r_q.guard_cnt > 9'h001)
                  begin
                     r_d.guard_cnt = r_q.guard_cnt - 9'h001;
                  end
                  else
                  begin
                     r_d.guard_cnt = 9'h000;
                     r_d.tx_ready  = 1'b1;
                  end
               end
               if (r_q.tx_ready && tx_valid && tx_mode_select)
               begin
                  r_d.tx_ready = 1'b0;
                  r_d.shift    = {2'b11, ^tx_data, tx_data};
                  r_d.bit_cnt  = TX_FRAME_BITS;
                  r_d.state    = ST_TX_SHIFT;
                  r_d.drv_one  = 1'b0;
               end
            end
            ST_TX_SHIFT:
            begin
               // Released line read low means another driver
               if (rise && !r_q.out_oe && !ldata && r_q.bit_cnt != TX_FRAME_BITS)
               begin
                  r_d.coll   = 1'b1;
                  r_d.out_oe = 1'b0;
                  r_d.state  = ST_RX_IDLE;
               end
               else if (fall)
               begin
                  if (r_q.bit_cnt == BIT_CNT_LAST)
                  begin
                     r_d.out_oe  = 1'b0;
                     r_d.tx_done = 1'b1;
                     r_d.state   = ST_TX_DONE;
                  end
                  else
                  begin
                     // Start bit, then LSB first data, parity, stops
                     if (r_q.bit_cnt == TX_FRAME_BITS)
                     begin
                        r_d.out_bit = 1'b0;
                     end
                     else
                     begin
                        r_d.out_bit = r_q.shift[0];
                        r_d.shift   = {1'b1, r_q.shift[10:1]};
                     end
                     // Zeros always driven, a one only on its first bit
                     r_d.out_oe  = ~r_d.out_bit | ~r_q.drv_one;
                     r_d.drv_one = r_d.out_bit;
                     r_d.bit_cnt = r_q.bit_cnt - 4'h1;
                  end
               end
            end
            ST_TX_DONE:
            begin
               // Next byte back to back, or return to receive
               if (!tx_mode_select)
               begin
                  r_d.state = ST_RX_IDLE;
               end
               else
               begin
                  r_d.tx_ready = 1'b1;
                  r_d.state    = ST_TX_GUARD;
                  r_d.guard_cnt = 9'h000;
               end
            end
            default:
            begin
               r_d.state = ST_OFF;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         r_q           <= '0;
         r_q.state     <= ST_OFF;
         r_q.guard_cfg <= GUARD_RESET;
         r_q.out_bit   <= 1'b1;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // Outputs straight from flip-flops
   assign prog_link_data_pin_out = r_q.out_bit;
   assign prog_link_data_pin_oe  = r_q.out_oe;
   assign tx_ready       = r_q.tx_ready;
   assign tx_done        = r_q.tx_done;
   assign rx_data        = r_q.rx_data;
   assign rx_valid       = r_q.rx_valid;
   assign frame_error    = r_q.frame_err;
   assign parity_error   = r_q.par_err;
   assign break_detected = r_q.brk;
   assign collision      = r_q.coll;
   assign link_enabled   = r_q.was_enabled;
endmodule
`default_nettype wire

// *** testbench/prog_link_phy_layer_assertions.sv ***
// Port checker for the programming link physical layer
`default_nettype none
module prog_link_phy_layer_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Session control
   input wire logic reset_pin_low,
   input wire logic reset_pin_high_voltage,
   input wire logic reset_pin_disable_fuse,
   input wire logic memory_access_enable_bit,
   input wire logic link_enabled,
   // Access layer side
   input wire logic tx_mode_select,
   input wire logic tx_ready,
   input wire logic tx_done,
   input wire logic prog_link_data_pin_oe,
   input wire logic rx_valid,
   input wire logic frame_error,
   input wire logic parity_error,
   input wire logic break_detected,
   input wire logic collision
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Exceptions ride on the frame-complete pulse
   err_valid_a: assert property (
      (frame_error || parity_error || break_detected) |-> rx_valid)
      else $error("exception without rx_valid");
   brk_alone_a: assert property (break_detected |-> !frame_error && !parity_error)
      else $error("break flagged with other errors");
   rx_in_session_a: assert property (rx_valid |-> link_enabled)
      else $error("frame received while disabled");
   rx_not_tx_a: assert property (rx_valid |-> !tx_ready)
      else $error("frame received in transmit mode");
   ready_needs_mode_a: assert property (tx_ready |-> $past(tx_mode_select))
      else $error("tx_ready without transmit mode");
   // Enable paths, allowing for the pin synchroniser lag
   low_enable_a: assert property (
      (reset_pin_low && !reset_pin_disable_fuse) [*8] |-> link_enabled)
      else $error("low reset pin did not enable");
   hv_enable_a: assert property (
      (reset_pin_high_voltage && reset_pin_disable_fuse) [*8] |-> link_enabled)
      else $error("high voltage did not enable");
   low_release_a: assert property (
      (!reset_pin_low && !reset_pin_high_voltage && !memory_access_enable_bit) [*8]
      |-> !link_enabled)
      else $error("link stayed enabled after release");
   keep_session_a: assert property (
      link_enabled && memory_access_enable_bit |=> link_enabled)
      else $error("session ended with memory access set");
   // Both stop bits are ones, so the line is already released at the end
   done_released_a: assert property (
      tx_done |-> !prog_link_data_pin_oe && $past(!prog_link_data_pin_oe))
      else $error("driver still on at frame end");
   good_rx_c: cover property (rx_valid && !frame_error && !parity_error);
   brk_c: cover property (break_detected);
   tx_end_c: cover property (tx_done);
   clash_c: cover property (collision);
endmodule
bind prog_link_phy_layer prog_link_phy_layer_checker chk_i (.*);
`default_nettype wire

// *** testbench/prog_link_programmer.sv ***
// Behavioural programmer at the far end of the link
`default_nettype none
module prog_link_programmer (
   // Link pins
   output logic      link_clk,
   output logic      drv_en,
   output logic      drv_val,
   input  wire logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] got;
   // Clock stands high and data is released between frames
   initial
   begin
      link_clk = 1'b1;
      drv_en = 1'b0;
      drv_val = 1'b1;
      got = 16'h0000;
   end
   // Start, data LSB first, even parity, two stops; errors injectable
   function automatic logic [15:0] frame(input logic [7:0] d, input logic pe, input logic sb);
      return {4'hF, 1'b1, ~sb, (^d) ^ pe, d, 1'b0};
   endfunction
   // Long low phase leaves room for the device's synchroniser lag
   // Pins move 1 ns after the device clock edges, never on them
   task automatic bits(input logic [15:0] v, input int n, input logic [15:0] dm);
      for (int i = 0; i < n; i++)
      begin
         #1 link_clk = 1'b0;
         drv_en = dm[i[3:0]];
         drv_val = v[i[3:0]];
         #55 link_clk = 1'b1;
         got[i[3:0]] = line;
         #24;
      end
      #1 drv_en = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** testbench/test_prog_link_phy_layer.sv ***
// Self-checking bench for the programming link physical layer
`default_nettype none
module test_prog_link_phy_layer;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] d; logic pe; logic sb; logic [2:0] ex;} row_t;
   logic clk_sys = 1'b0, rst = 1'b1, p_en, p_val;
   logic reset_pin_low = 1'b0, reset_pin_high_voltage = 1'b0, reset_pin_disable_fuse = 1'b0;
   logic memory_access_enable_bit = 1'b0, guard_time_load = 1'b0, tx_mode_select = 1'b0;
   logic tx_valid = 1'b0;
   logic [7:0] phy_guard_time_control = 8'h00, tx_data = 8'h00, rx_data;
   logic prog_link_clock_pin, prog_link_data_pin_in, prog_link_data_pin_out, prog_link_data_pin_oe;
   logic tx_ready, tx_done, rx_valid, frame_error, parity_error, break_detected, collision;
   logic link_enabled;
   logic [4:0] seen;
   int n_valid, error_cnt = 0, tests_run = 0;
   // Expected {break, parity, frame} beside each frame
   row_t rows [5] = '{'{8'hA5, 1'b0, 1'b0, 3'h0}, '{8'h00, 1'b0, 1'b0, 3'h0},
      '{8'hFF, 1'b0, 1'b0, 3'h0}, '{8'h3C, 1'b1, 1'b0, 3'h2}, '{8'h81, 1'b0, 1'b1, 3'h1}};
   always #5 clk_sys = ~clk_sys;
   prog_link_phy_layer dut (.*);
   prog_link_programmer prog (.link_clk(prog_link_clock_pin), .drv_en(p_en), .drv_val(p_val),
      .line(prog_link_data_pin_in));
   // Pull-up wins only when neither side drives
   assign prog_link_data_pin_in = (prog_link_data_pin_oe ? prog_link_data_pin_out : 1'b1)
      & (p_en ? p_val : 1'b1);
   // Pulses are one cycle wide, so gather them as sticky flags
   // Mid-cycle sampling keeps clear-on-edge free of races
   always @(negedge clk_sys)
   begin
      n_valid <= n_valid + int'(rx_valid);
      seen <= seen | {collision, tx_done, break_detected, parity_error, frame_error};
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] ex);
      tests_run++;
      if (got !== ex)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, ex);
      end
   endtask
   task automatic clr();
      seen = 5'h00;
      n_valid = 0;
   endtask
   task automatic send(input logic [7:0] b);
      tx_data <= b;
      tx_valid <= 1'b1;
      @(posedge clk_sys);
      tx_valid <= 1'b0;
   endtask
   task end_sim();
      $display("tests %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Run spans about 23 us; a hang is cut well after that
   initial
   begin
      #200_000;
      error_cnt++;
      $display("watchdog expired");
      end_sim();
   end
   initial
   begin
      clr();
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk({prog_link_data_pin_oe, prog_link_data_pin_out, tx_ready, link_enabled}, 16'h0004);
      reset_pin_low <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk(link_enabled, 16'h0001);
      prog.bits(16'hFFFF, 16, 16'hFFFF);
      foreach (rows[i])
      begin
         clr();
         prog.bits(prog.frame(rows[i].d, rows[i].pe, rows[i].sb), 12, 16'hFFFF);
         repeat (10) @(posedge clk_sys);
         chk({n_valid[3:0], seen[2:0]}, {4'h1, rows[i].ex});
         chk(rx_data, rows[i].d);
      end
      $display("receive rows done");
      clr();
      prog.bits(16'h0000, 14, 16'hFFFF);
      prog.bits(16'hFFFF, 2, 16'hFFFF);
      repeat (10) @(posedge clk_sys);
      chk({n_valid[3:0], 9'h000, seen[2:0]}, {4'h1, 9'h000, 3'h4});
      $display("break done");
      clr();
      tx_mode_select <= 1'b1;
      prog.bits(16'hFFFF, 129, 16'h0000);
      repeat (10) @(posedge clk_sys);
      chk(tx_ready, 16'h0000);
      prog.bits(16'hFFFF, 1, 16'h0000);
      repeat (10) @(posedge clk_sys);
      chk(tx_ready, 16'h0001);
      send(8'h96);
      prog.bits(16'hFFFF, 13, 16'h0000);
      repeat (10) @(posedge clk_sys);
      chk(prog.got & 16'h0FFF, prog.frame(8'h96, 1'b0, 1'b0) & 16'h0FFF);
      chk({seen[3], tx_ready}, 16'h0003);
      clr();
      send(8'hFF);
      prog.bits(16'h0000, 13, 16'h0010);
      @(posedge clk_sys);
      tx_mode_select <= 1'b0;
      prog.bits(16'hFFFF, 16, 16'hFFFF);
      chk(seen[4:3], 16'h0002);
      $display("transmit done");
      // Programmed guard of zero leaves only the two idle bits
      @(posedge clk_sys);
      phy_guard_time_control <= 8'h00;
      guard_time_load <= 1'b1;
      @(posedge clk_sys);
      guard_time_load <= 1'b0;
      tx_mode_select <= 1'b1;
      prog.bits(16'hFFFF, 1, 16'h0000);
      repeat (10) @(posedge clk_sys);
      chk(tx_ready, 16'h0000);
      prog.bits(16'hFFFF, 1, 16'h0000);
      repeat (10) @(posedge clk_sys);
      chk(tx_ready, 16'h0001);
      tx_mode_select <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk(tx_ready, 16'h0000);
      $display("guard done");
      reset_pin_low <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk(link_enabled, 16'h0000);
      reset_pin_low <= 1'b1;
      memory_access_enable_bit <= 1'b1;
      repeat (10) @(posedge clk_sys);
      reset_pin_low <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk(link_enabled, 16'h0001);
      rst <= 1'b1;
      memory_access_enable_bit <= 1'b0;
      reset_pin_disable_fuse <= 1'b1;
      reset_pin_high_voltage <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk(link_enabled, 16'h0001);
      $display("session done");
      end_sim();
   end
endmodule
`default_nettype wire
